// ===== logic/pmirq_pkg.sv
// Constants, register map and carrier types of the interrupt block and its serial port.
// Assumes a 40 MHz system clock; pins are synchronised inside the design.
`default_nettype none
package pmirq_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h34;
    localparam logic [7:0] REG_IRQ_EN   = 8'h40;
    localparam logic [7:0] REG_IRQ_STAT = 8'h48;
    localparam logic [7:0] REG_TMR      = 8'h8a;
    localparam logic [7:0] REG_TWARN    = 8'h8d;
    localparam logic [7:0] REG_HOT      = 8'h8f;
    localparam logic [7:0] REG_GPIO0    = 8'h90;
    localparam logic [7:0] REG_GPIO1    = 8'h92;
    localparam logic [7:0] REG_BWARN    = 8'he6;
    localparam int BIT_TMR    = 2;
    localparam int BIT_BATLOW = 3;
    localparam int BIT_OTEMP  = 4;
    localparam int GPIO_REN_BIT = 6;
    localparam int GPIO_FEN_BIT = 7;
    localparam int HOT_SHDN_BIT = 2;
    localparam logic [2:0] GPIO_FN_DIN = 3'h2;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_GPIO   = 8'h07;
    localparam logic [7:0] RST_TMR    = 8'h00;
    localparam logic [7:0] RST_HOT    = 8'h00;
    localparam logic [7:0] RST_BWARN  = 8'h0a;
    localparam logic [7:0] RST_TWARN  = 8'hff;
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEB_TIME_NS   = 1000000;
    localparam int TICK_TIME_NS  = 1000000;
    localparam int DEB_CYCLES_DEF  = DEB_TIME_NS / CLK_PERIOD_NS;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } pmirq_wr_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AACK  = 3'h3,
        ST_RX    = 3'h2,
        ST_RXACK = 3'h6,
        ST_TX    = 3'h7,
        ST_TXACK = 3'h5
    } pmirq_i2c_state_type;
endpackage
`default_nettype wire

// ===== logic/pmirq_sync.sv
// Two flip-flop synchroniser for pins entering the system clock domain.
// Assumes inputs are asynchronous levels.
`default_nettype none
module pmirq_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Levels
    input  wire logic [W-1:0] in_async,
    output logic      [W-1:0] out_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= '0;
            out_sync <= '0;
        end else begin
            meta_reg <= in_async;
            out_sync <= meta_reg;
        end
    end
endmodule // pmirq_sync
`default_nettype wire

// ===== logic/pmirq_debounce.sv
// Debounce and edge detection of one GPIO pin.
// Assumes an asynchronous pin; rise and fall are one-cycle pulses.
`default_nettype none
module pmirq_debounce #(
    parameter int unsigned DEB_CYCLES = pmirq_pkg::DEB_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Pin and result
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DEB_CYCLES - 1);

    logic          pin_s;
    logic [CW-1:0] cnt_reg;

    pmirq_sync #(.W(1)) u_sync (
        .clk      (clk),
        .srst     (srst),
        .in_async (pin_i),
        .out_sync (pin_s)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (pin_s == level_o) begin
                cnt_reg <= '0;
            end else if (cnt_reg == LAST) begin
                cnt_reg <= '0;
                level_o <= pin_s;
                rise_o  <= pin_s;
                fall_o  <= ~pin_s;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_deb_window;
        $changed(level_o) |-> $past(cnt_reg) == LAST;
    endproperty
    a_deb_window: assert property (p_deb_window) else $error("level moved before debounce window");

    property p_deb_edge;
        rise_o |-> level_o && !$past(level_o) && !fall_o;
    endproperty
    a_deb_edge: assert property (p_deb_edge) else $error("rise pulse without rising level");
endmodule // pmirq_debounce
`default_nettype wire

// ===== logic/pmirq_top.sv
// Interrupt aggregation with serial register port.
// Assumes open-drain pins resolved outside; monitor inputs come from logic on clk.
`default_nettype none
module pmirq_top #(
    parameter int unsigned DEB_CYCLES  = pmirq_pkg::DEB_CYCLES_DEF,
    parameter int unsigned TICK_CYCLES = pmirq_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Supply state
    input  wire logic        supply_low,
    input  wire logic        power_off,
    // Serial port
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Interrupt pin
    output logic             irq_o,
    output logic             irq_oe,
    // GPIO pins
    input  wire logic [1:0]  gpio_i,
    // Monitors
    input  wire logic [6:0]  batt_pct,
    input  wire logic [11:0] temp_adc,
    output logic             shutdown_req
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [2:0]                     pin_s;
    logic                           scl_s, sda_s, scl_q, sda_q;
    logic                           por_rst, sys_rst;
    logic                           start_c, stop_c, scl_rise, scl_fall;
    pmirq_pkg::pmirq_i2c_state_type state_reg;
    logic [3:0]                     bit_cnt_reg;
    logic [7:0]                     shift_reg, tx_reg, ptr_reg, rd_data;
    logic                           rw_reg, first_reg, nack_reg;
    pmirq_pkg::pmirq_wr_type        wr_reg;
    logic [7:0]                     en_reg, stat_reg, stat_next, clr_mask, ev;
    logic [7:0]                     tmr_cfg_reg, tmr_cnt_reg, hot_reg, bwarn_reg, twarn_reg;
    logic [7:0]                     gpio_ctrl_reg [2];
    logic [1:0]                     gpio_lvl, gpio_rise, gpio_fall, gpio_ev;
    logic [TW-1:0]                  tick_cnt_reg;
    logic                           tick, tmr_ev, bat_now, bat_reg, ot_now, ot_reg;

    pmirq_sync #(.W(3)) u_sync (
        .clk      (clk),
        .srst     (srst),
        .in_async ({supply_low, sda_i, scl_i}),
        .out_sync (pin_s)
    );
    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];

    assign por_rst = srst | pin_s[2];
    assign sys_rst = por_rst | power_off;

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_q <= 1'b0;
            sda_q <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;

    always_comb begin
        if (ptr_reg == pmirq_pkg::REG_IRQ_EN) begin
            rd_data = en_reg;
        end else if (ptr_reg == pmirq_pkg::REG_IRQ_STAT) begin
            rd_data = stat_reg;
        end else if (ptr_reg == pmirq_pkg::REG_TMR) begin
            rd_data = tmr_cfg_reg;
        end else if (ptr_reg == pmirq_pkg::REG_TWARN) begin
            rd_data = twarn_reg;
        end else if (ptr_reg == pmirq_pkg::REG_HOT) begin
            rd_data = hot_reg;
        end else if (ptr_reg == pmirq_pkg::REG_GPIO0) begin
            rd_data = gpio_ctrl_reg[0];
        end else if (ptr_reg == pmirq_pkg::REG_GPIO1) begin
            rd_data = gpio_ctrl_reg[1];
        end else if (ptr_reg == pmirq_pkg::REG_BWARN) begin
            rd_data = bwarn_reg;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Serial slave; START/STOP take priority over data edges
    always_ff @(posedge clk) begin
        if (por_rst) begin
            state_reg   <= pmirq_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            rw_reg      <= 1'b0;
            first_reg   <= 1'b0;
            nack_reg    <= 1'b0;
            sda_oe      <= 1'b0;
            wr_reg      <= '0;
        end else begin
            wr_reg.valid <= 1'b0;
            if (start_c) begin
                state_reg   <= pmirq_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe      <= 1'b0;
            end else if (stop_c) begin
                state_reg <= pmirq_pkg::ST_IDLE;
                sda_oe    <= 1'b0;
            end else if (scl_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (state_reg == pmirq_pkg::ST_ADDR || state_reg == pmirq_pkg::ST_RX) begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                end
                if (state_reg == pmirq_pkg::ST_TXACK) begin
                    nack_reg <= sda_s;
                end
            end else if (scl_fall) begin
                case (state_reg)
                    pmirq_pkg::ST_ADDR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            if (shift_reg[7:1] == pmirq_pkg::DEV_ADDR) begin
                                state_reg <= pmirq_pkg::ST_AACK;
                                sda_oe    <= 1'b1;
                                rw_reg    <= shift_reg[0];
                                first_reg <= 1'b1;
                            end else begin
                                state_reg <= pmirq_pkg::ST_IDLE;
                            end
                        end
                    end
                    pmirq_pkg::ST_AACK: begin
                        if (bit_cnt_reg != 4'h0) begin
                            bit_cnt_reg <= 4'h0;
                            if (rw_reg) begin
                                state_reg <= pmirq_pkg::ST_TX;
                                tx_reg    <= rd_data;
                                sda_oe    <= ~rd_data[7];
                            end else begin
                                state_reg <= pmirq_pkg::ST_RX;
                                sda_oe    <= 1'b0;
                            end
                        end
                    end
                    pmirq_pkg::ST_RX: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= pmirq_pkg::ST_RXACK;
                            sda_oe      <= 1'b1;
                            first_reg   <= 1'b0;
                            if (first_reg) begin
                                ptr_reg <= shift_reg;
                            end else begin
                                wr_reg  <= '{valid: 1'b1, addr: ptr_reg, data: shift_reg};
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                        end
                    end
                    pmirq_pkg::ST_RXACK: begin
                        if (bit_cnt_reg != 4'h0) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= pmirq_pkg::ST_RX;
                            sda_oe      <= 1'b0;
                        end
                    end
                    pmirq_pkg::ST_TX: begin
                        if (bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= pmirq_pkg::ST_TXACK;
                            sda_oe      <= 1'b0;
                            ptr_reg     <= ptr_reg + 8'h01;
                        end else begin
                            sda_oe <= ~tx_reg[~bit_cnt_reg[2:0]];
                        end
                    end
                    pmirq_pkg::ST_TXACK: begin
                        if (bit_cnt_reg != 4'h0) begin
                            bit_cnt_reg <= 4'h0;
                            if (nack_reg) begin
                                state_reg <= pmirq_pkg::ST_IDLE;
                            end else begin
                                state_reg <= pmirq_pkg::ST_TX;
                                tx_reg    <= rd_data;
                                sda_oe    <= ~rd_data[7];
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Open-drain pins only ever drive low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
        irq_o <= 1'b0;
    end

    // System-class control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_reg           <= pmirq_pkg::RST_IRQ_EN;
            hot_reg          <= pmirq_pkg::RST_HOT;
            gpio_ctrl_reg[0] <= pmirq_pkg::RST_GPIO;
            gpio_ctrl_reg[1] <= pmirq_pkg::RST_GPIO;
        end else if (wr_reg.valid) begin
            if (wr_reg.addr == pmirq_pkg::REG_IRQ_EN) begin
                en_reg <= wr_reg.data;
            end else if (wr_reg.addr == pmirq_pkg::REG_HOT) begin
                hot_reg <= wr_reg.data;
            end else if (wr_reg.addr == pmirq_pkg::REG_GPIO0) begin
                gpio_ctrl_reg[0] <= wr_reg.data;
            end else if (wr_reg.addr == pmirq_pkg::REG_GPIO1) begin
                gpio_ctrl_reg[1] <= wr_reg.data;
            end
        end
    end

    // Power-on-class thresholds survive a plain power-off
    always_ff @(posedge clk) begin
        if (por_rst) begin
            bwarn_reg <= pmirq_pkg::RST_BWARN;
            twarn_reg <= pmirq_pkg::RST_TWARN;
        end else if (wr_reg.valid) begin
            if (wr_reg.addr == pmirq_pkg::REG_BWARN) begin
                bwarn_reg <= wr_reg.data;
            end else if (wr_reg.addr == pmirq_pkg::REG_TWARN) begin
                twarn_reg <= wr_reg.data;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_gpio
            pmirq_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
                .clk     (clk),
                .srst    (sys_rst),
                .pin_i   (gpio_i[g]),
                .level_o (gpio_lvl[g]),
                .rise_o  (gpio_rise[g]),
                .fall_o  (gpio_fall[g])
            );
            assign gpio_ev[g] = (gpio_ctrl_reg[g][2:0] == pmirq_pkg::GPIO_FN_DIN)
                              & ((gpio_rise[g] & gpio_ctrl_reg[g][pmirq_pkg::GPIO_REN_BIT])
                              | (gpio_fall[g] & gpio_ctrl_reg[g][pmirq_pkg::GPIO_FEN_BIT]));
        end
    endgenerate

    // timer, reloaded only by a write to its register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tmr_cfg_reg  <= pmirq_pkg::RST_TMR;
            tmr_cnt_reg  <= pmirq_pkg::RST_TMR;
            tick_cnt_reg <= '0;
        end else if (wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_TMR) begin
            tmr_cfg_reg  <= wr_reg.data;
            tmr_cnt_reg  <= wr_reg.data;
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
            if (tick && tmr_cnt_reg != 8'h00) begin
                tmr_cnt_reg <= tmr_cnt_reg - 8'h01;
            end
        end
    end
    assign tick   = tick_cnt_reg == TW'(TICK_CYCLES - 1);
    assign tmr_ev = tick && tmr_cnt_reg == 8'h01
                    && !(wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_TMR);

    assign bat_now = {1'b0, batt_pct} < bwarn_reg;
    assign ot_now  = temp_adc[11:4] >= twarn_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bat_reg      <= 1'b0;
            ot_reg       <= 1'b0;
            shutdown_req <= 1'b0;
        end else begin
            bat_reg      <= bat_now;
            ot_reg       <= ot_now;
            shutdown_req <= ot_now & hot_reg[pmirq_pkg::HOT_SHDN_BIT];
        end
    end

    assign ev = {3'h0, ot_now & ~ot_reg, bat_now & ~bat_reg, tmr_ev, gpio_ev};
    assign clr_mask = (wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_IRQ_STAT) ? wr_reg.data : 8'h00;
    // write one clears; a new event wins
    assign stat_next = (stat_reg & ~clr_mask) | ev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_reg <= 8'h00;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_oe <= 1'b0;
        end else begin
            irq_oe <= |(stat_reg & en_reg);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_irq_hold;
        (|(stat_reg & en_reg)) |=> irq_oe;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("enabled status did not pull irq low");

    property p_irq_mask;
        !(|(stat_reg & en_reg)) |=> !irq_oe;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq asserted without enabled status");

    property p_clear_one;
        (wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_IRQ_STAT && ev == 8'h00)
            |=> (stat_reg & $past(wr_reg.data)) == 8'h00;
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("status bit not cleared by one");

    property p_keep_zero;
        (wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_IRQ_STAT)
            |=> (($past(stat_reg) & ~$past(wr_reg.data)) & ~stat_reg) == 8'h00;
    endproperty
    a_keep_zero: assert property (p_keep_zero) else $error("status bit lost on zero write");

    property p_tmr_expire;
        (tick && tmr_cnt_reg == 8'h01 && !wr_reg.valid) |=> stat_reg[pmirq_pkg::BIT_TMR] && tmr_cnt_reg == 8'h00;
    endproperty
    a_tmr_expire: assert property (p_tmr_expire) else $error("timer expiry did not raise event");

    property p_tmr_norestart;
        (wr_reg.valid && wr_reg.addr == pmirq_pkg::REG_IRQ_STAT && !tick) |=> tmr_cnt_reg == $past(tmr_cnt_reg);
    endproperty
    a_tmr_norestart: assert property (p_tmr_norestart) else $error("status clear touched timer");

    property p_batlow;
        (bat_now && !bat_reg) |=> stat_reg[pmirq_pkg::BIT_BATLOW] ##1 irq_oe == en_reg[pmirq_pkg::BIT_BATLOW] || irq_oe;
    endproperty
    a_batlow: assert property (p_batlow) else $error("low battery event missed");

    property p_otemp;
        (ot_now && !ot_reg) |=> stat_reg[pmirq_pkg::BIT_OTEMP] && shutdown_req == hot_reg[pmirq_pkg::HOT_SHDN_BIT];
    endproperty
    a_otemp: assert property (p_otemp) else $error("over temperature event or shutdown wrong");

    property p_gpio_din;
        $rose(stat_reg[0]) |-> $past(gpio_ctrl_reg[0][2:0]) == pmirq_pkg::GPIO_FN_DIN;
    endproperty
    a_gpio_din: assert property (p_gpio_din) else $error("gpio event while not digital input");

    property p_addr_ignore;
        (state_reg == pmirq_pkg::ST_ADDR && scl_fall && !start_c && !stop_c && bit_cnt_reg == 4'h8
            && shift_reg[7:1] != pmirq_pkg::DEV_ADDR) |=> state_reg == pmirq_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acknowledged");

    property p_ptr_inc;
        (state_reg == pmirq_pkg::ST_TX && scl_fall && !start_c && !stop_c && bit_cnt_reg == 4'h8)
            |=> ptr_reg == $past(ptr_reg) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("read pointer did not advance");
endmodule // pmirq_top
`default_nettype wire

// ===== testbench/pmirq_host.sv
// Host side of the serial port: a bus master with open-drain SDA.
// Assumes SDA has a pull-up; SCL stands high between frames.
`default_nettype none
module pmirq_host (
    // Bus
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit, 200 ns period; data moves mid low phase
    task automatic bitx(input logic b, output logic r);
        sda_pull = ~b;
        #50 scl = 1'b1;
        #50 r = sda_in;
        #50 scl = 1'b0;
        #50;
    endtask
    // Waits out any slave ACK before a repeated start
    task automatic start;
        #100 sda_pull = 1'b0;
        #50 scl = 1'b1;
        #50 sda_pull = 1'b1;
        #100 scl = 1'b0;
        #50;
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        #50 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask
    // send MSB first, then ack bit
    task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(am, ak);
    endtask
endmodule // pmirq_host
`default_nettype wire

// ===== testbench/pmirq_bench.sv
// Self-checking bench: host model on the port, bench drives monitors.
// Assumes short debounce and tick counts set below.
`default_nettype none
module pmirq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1;
    logic [1:0] gpio = 0;
    logic [6:0] batt = 7'h50;
    logic pwr_off = 0, sup_low = 0;
    logic [11:0] temp = 0;
    logic sda_o, sda_oe, irq_o, irq_oe, shdn, hp, q_k;
    logic [7:0] got, q;
    logic [7:0] exp_q[$];
    wire scl, sda;
    event ev;
    int error_cnt = 0, tests_run = 0;
    assign sda = ~(hp | sda_oe);
    initial forever #12.5 clk = ~clk;
    pmirq_top #(.DEB_CYCLES(8), .TICK_CYCLES(16)) pmirq_top_inst (.clk(clk), .srst(srst),
        .supply_low(sup_low), .power_off(pwr_off), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq_o(irq_o), .irq_oe(irq_oe), .gpio_i(gpio), .batt_pct(batt),
        .temp_adc(temp), .shutdown_req(shdn));
    pmirq_host pmirq_host_inst (.sda_in(sda), .scl(scl), .sda_pull(hp));
    initial forever begin
        @(ev);
        tests_run++;
        if (got !== exp_q[0]) begin
            $display("FAIL t=%0t exp=%h got=%h", $time, exp_q[0], got);
            error_cnt++;
        end
        void'(exp_q.pop_front());
    end
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        exp_q.push_back(e);
        got = g;
        -> ev;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pmirq_host_inst.start;
        pmirq_host_inst.xfer(8'h68, 1'b1, q, q_k);
        pmirq_host_inst.xfer(a, 1'b1, q, q_k);
        pmirq_host_inst.xfer(d, 1'b1, q, q_k);
        chk(8'h00, {7'h00, q_k});
        pmirq_host_inst.stop;
    endtask
    task automatic rd2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        pmirq_host_inst.start;
        pmirq_host_inst.xfer(8'h68, 1'b1, q, q_k);
        pmirq_host_inst.xfer(a, 1'b1, q, q_k);
        pmirq_host_inst.start;
        pmirq_host_inst.xfer(8'h69, 1'b1, q, q_k);
        pmirq_host_inst.xfer(8'hff, 1'b0, q, q_k);
        chk(e0, q);
        pmirq_host_inst.xfer(8'hff, 1'b1, q, q_k);
        chk(e1, q);
        pmirq_host_inst.stop;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        #1ms;
        error_cnt++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'h2cdb));
        cyc(20);
        srst <= 1'b0;
        cyc(4);
        chk(8'h00, {7'h00, irq_oe});
        chk(8'h00, {6'h00, irq_o, sda_o});
        pmirq_host_inst.start;
        pmirq_host_inst.xfer(8'h6a, 1'b1, q, q_k);
        chk(8'h01, {7'h00, q_k});
        pmirq_host_inst.stop;
        wr(8'h40, 8'h00);
        @(posedge clk) batt <= 7'($urandom % 10);
        cyc(4);
        chk(8'h00, {7'h00, irq_oe});
        rd2(8'h48, 8'h08, 8'h00);
        wr(8'h40, 8'h1f);
        cyc(4);
        chk(8'h01, {7'h00, irq_oe});
        wr(8'h48, 8'h00);
        rd2(8'h48, 8'h08, 8'h00);
        wr(8'h48, 8'h08);
        cyc(4);
        chk(8'h00, {7'h00, irq_oe});
        wr(8'h8a, 8'h02);
        for (int i = 0; i < 100 && irq_oe !== 1'b1; i++) cyc(1);
        chk(8'h01, {7'h00, irq_oe});
        rd2(8'h48, 8'h04, 8'h00);
        wr(8'h48, 8'h04);
        cyc(100);
        rd2(8'h48, 8'h00, 8'h00);
        wr(8'h90, 8'h42);
        @(posedge clk) gpio <= 2'b11;
        cyc(40);
        rd2(8'h48, 8'h01, 8'h00);
        wr(8'h48, 8'h01);
        @(posedge clk) gpio <= 2'b00;
        cyc(40);
        rd2(8'h48, 8'h00, 8'h00);
        wr(8'h8d, 8'h10);
        wr(8'h8f, 8'h04);
        @(posedge clk) temp <= 12'h100 + 12'($urandom % 16);
        cyc(4);
        chk(8'h01, {7'h00, shdn});
        rd2(8'h48, 8'h10, 8'h00);
        wr(8'he6, 8'h20);
        @(posedge clk) pwr_off <= 1'b1;
        cyc(2);
        pwr_off <= 1'b0;
        cyc(4);
        chk(8'h00, {6'h00, shdn, irq_oe});
        rd2(8'h40, 8'h00, 8'h00);
        rd2(8'h48, 8'h18, 8'h00);
        rd2(8'he6, 8'h20, 8'h00);
        @(posedge clk) sup_low <= 1'b1;
        cyc(4);
        sup_low <= 1'b0;
        cyc(6);
        rd2(8'he6, 8'h0a, 8'h00);
        give_verdict;
    end
endmodule // pmirq_bench
`default_nettype wire
